/* File: dv/eight_bit_timer_counter_tb.sv */
// self-checking bench for the eight bit timer/counter
module eight_bit_timer_counter_tb
   import tmr8_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;

   logic               i_clk_sys = 1'b0;
   logic               i_rst_n   = 1'b0;
   logic               src_sel   = 1'b0;
   logic               edge_sel  = 1'b0;
   logic               bypass    = 1'b1;
   logic [RATE_W-1:0]  rate      = 3'h0;
   logic               irq_en    = 1'b1;
   logic               wr        = 1'b0;
   logic               flag_clr  = 1'b0;
   logic [COUNT_W-1:0] wdata     = 8'h00;
   logic [COUNT_W-1:0] count;
   logic               flag;
   logic               irq;
   logic               gate;
   logic               pin;
   int                 bad_count = 0;
   int                 checked   = 0;

   always #10 i_clk_sys = ~i_clk_sys;

   ext_count_source i_src (.i_clk_sys(i_clk_sys), .o_pin(pin));

   tmr8_timer i_dut (
      .i_clk_sys              (i_clk_sys),
      .i_rst_n                (i_rst_n),
      .i_clock_source_select  (src_sel),
      .i_source_edge_select   (edge_sel),
      .i_prescaler_bypass     (bypass),
      .i_prescale_rate_select (rate),
      .i_overflow_irq_enable  (irq_en),
      .i_count_write          (wr),
      .i_count_wdata          (wdata),
      .o_count_register       (count),
      .i_overflow_flag_clear  (flag_clr),
      .o_overflow_flag        (flag),
      .o_overflow_irq         (irq),
      .o_overflow_gate        (gate),
      .i_external_count_input (pin)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      if (bad_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   task automatic write_count(input logic [COUNT_W-1:0] v);
      @(negedge i_clk_sys) {wr, wdata} = {1'b1, v};
      @(negedge i_clk_sys) wr = 1'b0;
   endtask : write_count

   task automatic timer_walk();
      logic [COUNT_W-1:0] ew [5] = '{8'hFE, 8'hFE, 8'hFE, 8'hFF, 8'h00};
      write_count(8'hFE);
      for (int i = 0; i < 5; i++) begin
         if (i > 0) @(negedge i_clk_sys);
         check(count, ew[i]);
      end
      check({flag, gate, irq}, 3'h7);
      @(negedge i_clk_sys) irq_en = 1'b0;
      check({gate, count}, 9'h001);
      @(negedge i_clk_sys) flag_clr = 1'b1;
      check({flag, irq}, 2'h2);
      @(negedge i_clk_sys) {flag_clr, irq_en} = 2'h1;
      check(flag, 1'b0);
      // back-to-back writes: the second restarts the hold-off
      @(negedge i_clk_sys) {wr, wdata} = {1'b1, 8'h10};
      @(negedge i_clk_sys) wdata = 8'h20;
      @(negedge i_clk_sys) wr = 1'b0;
      for (int i = 0; i < 4; i++) begin
         check(count, (i == 3) ? 8'h21 : 8'h20);
         @(negedge i_clk_sys);
      end
   endtask : timer_walk

   task automatic prescale_rates();
      int n;
      int t;
      logic [COUNT_W-1:0] c0;
      bypass = 1'b0;
      for (int r = 0; r < 8; r++) begin
         n = 2 << r;
         rate = r[RATE_W-1:0];
         write_count(8'h00);
         // leave the prescaler mid-way so a missed clear shows in the delay
         repeat (n + n / 2) @(negedge i_clk_sys);
         write_count(8'h00);
         for (t = 1; count === 8'h00 && t < 600; t++) @(negedge i_clk_sys);
         check(t >= n - 1 && t <= n + 4, 1'b1);
         c0 = count;
         for (t = 0; count === c0 && t < 600; t++) @(negedge i_clk_sys);
         check(t, n);
         check(count, c0 + 8'h01);
      end
      bypass = 1'b1;
   endtask : prescale_rates

   task automatic counter_edges();
      src_sel = SRC_EXTERNAL;
      for (int e = 0; e < 2; e++) begin
         edge_sel = e[0];
         write_count(8'h00);
         i_src.set_level(1'b1);
         repeat (4) @(negedge i_clk_sys);
         check(count, (edge_sel == EDGE_FALLING) ? 8'h00 : 8'h01);
         i_src.set_level(1'b0);
         repeat (4) @(negedge i_clk_sys);
         check(count, 8'h01);
         i_src.pulses(5);
         repeat (4) @(negedge i_clk_sys);
         check(count, 8'h06);
      end
      src_sel = 1'b0;
   endtask : counter_edges

   // clear and rollover in one cycle: the set must win
   task automatic flag_race();
      write_count(8'hFE);
      repeat (3) @(negedge i_clk_sys);
      flag_clr = 1'b1;
      @(negedge i_clk_sys) flag_clr = 1'b0;
      check({flag, gate, count}, 10'h300);
      @(negedge i_clk_sys) flag_clr = 1'b1;
      @(negedge i_clk_sys) flag_clr = 1'b0;
      check(flag, 1'b0);
   endtask : flag_race

   initial begin
      repeat (10) @(negedge i_clk_sys);
      check({count, flag, gate}, 10'h000);
      i_rst_n = 1'b1;
      timer_walk();
      flag_race();
      prescale_rates();
      counter_edges();
      print_verdict();
   end

   initial begin
      repeat (20000) @(posedge i_clk_sys);
      bad_count++;
      print_verdict();
   end
endmodule : eight_bit_timer_counter_tb

/* File: dv/ext_count_source.sv */
// model of the external clock source on the count input pin
module ext_count_source (
   // clock
   input  wire logic i_clk_sys,
   // pin
   output logic      o_pin
);
   timeunit 1ns;
   timeprecision 1ns;

   initial o_pin = 1'b0;

   // each level held 4 cycles: the design needs only 1 to see it
   task automatic set_level(input logic v);
      @(negedge i_clk_sys) o_pin = v;
      repeat (3) @(negedge i_clk_sys);
   endtask : set_level

   // pin rests low between bursts
   task automatic pulses(input int n);
      repeat (n) begin
         set_level(1'b1);
         set_level(1'b0);
      end
   endtask : pulses
endmodule : ext_count_source

/* File: hdl/tick_if.sv */
// carrier between the tick source and the count register
interface tick_if;
   logic tick;
   logic clear;

   modport source (input clear, output tick);
   modport sink   (input tick, output clear);
endinterface : tick_if

/* File: hdl/tmr8_pkg.sv */
// shared constants and types for the eight bit timer/counter
package tmr8_pkg;
   localparam int         COUNT_W        = 8;
   localparam int         RATE_W         = 3;
   localparam int         PRESCALE_W     = 8;
   localparam int         HOLD_W         = 2;
   localparam logic [1:0] WRITE_HOLD     = 2'h2;
   localparam logic [7:0] COUNT_RESET    = 8'h00;
   localparam logic [7:0] COUNT_MAX      = 8'hFF;
   localparam logic [7:0] PRESCALE_RESET = 8'h00;
   localparam logic       EDGE_FALLING   = 1'h1;
   localparam logic       SRC_EXTERNAL   = 1'h1;

   typedef enum logic {MODE_TIMER, MODE_COUNTER} count_mode_t;
endpackage : tmr8_pkg

/* File: hdl/tmr8_prescaler.sv */
// prescaler: divides raw count events by 2..256, or passes them 1:1
module tmr8_prescaler
   import tmr8_pkg::*;
#(
   parameter int WIDTH = PRESCALE_W
) (
   // clock and reset
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst_n,
   // configuration
   input  wire logic              i_prescaler_bypass,
   input  wire logic [RATE_W-1:0] i_prescale_rate_select,
   // raw events in
   input  wire logic              i_event,
   // divided ticks out
   tick_if.source                 tick_port
);
   logic [WIDTH-1:0] prescale_count;
   logic [WIDTH-1:0] next_prescale_count;
   logic             wrap;

   // rate n divides by 2^(n+1): wrap when the low n+1 bits are all ones
   function automatic logic at_wrap(input logic [WIDTH-1:0] cnt,
                                    input logic [RATE_W-1:0] rate);
      logic [WIDTH-1:0] mask;
      mask = WIDTH'((1 << (int'(rate) + 1)) - 1);
      return (cnt & mask) == mask;
   endfunction : at_wrap

   assign next_prescale_count = prescale_count + WIDTH'(1);
   assign wrap = at_wrap(prescale_count, i_prescale_rate_select);

   // not visible to software; only the count-register write clears it
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prescale_count <= PRESCALE_RESET;
      end else if (tick_port.clear) begin
         prescale_count <= PRESCALE_RESET;
      end else if (i_event && !i_prescaler_bypass) begin
         prescale_count <= wrap ? PRESCALE_RESET : next_prescale_count;
      end
   end

   assign tick_port.tick = i_event &&
                           (i_prescaler_bypass || wrap);

   default clocking chk_cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);

   pre_clear_a : assert property (
      tick_port.clear |=> prescale_count == PRESCALE_RESET)
      else $error("prescaler not cleared by count write");
   pre_bypass_a : assert property (
      (i_prescaler_bypass && i_event && !tick_port.clear) |-> tick_port.tick)
      else $error("bypassed event did not tick");
endmodule : tmr8_prescaler

/* File: hdl/tmr8_timer.sv */
// eight bit timer/counter with prescaler, write hold-off and overflow flag
module tmr8_timer
   import tmr8_pkg::*;
#(
   parameter int W = COUNT_W
) (
   // clock and reset
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst_n,
   // configuration
   input  wire logic              i_clock_source_select,
   input  wire logic              i_source_edge_select,
   input  wire logic              i_prescaler_bypass,
   input  wire logic [RATE_W-1:0] i_prescale_rate_select,
   input  wire logic              i_overflow_irq_enable,
   // count register access
   input  wire logic              i_count_write,
   input  wire logic [W-1:0]      i_count_wdata,
   output logic [W-1:0]           o_count_register,
   // flag
   input  wire logic              i_overflow_flag_clear,
   output logic                   o_overflow_flag,
   output logic                   o_overflow_irq,
   output logic                   o_overflow_gate,
   // pin
   input  wire logic              i_external_count_input
);
   count_mode_t       mode;
   logic              pin_meta;
   logic              pin_sync;
   logic              pin_last;
   logic              pin_rise;
   logic              pin_fall;
   logic              raw_event;
   logic [HOLD_W-1:0] hold;
   logic              rollover;
   tick_if            tick_bus ();

   // an increment is allowed only once the write hold-off has drained;
   // a write in the same cycle takes precedence over any tick
   function automatic logic step_allowed(input logic              tick,
                                         input logic [HOLD_W-1:0] left,
                                         input logic              wr);
      return tick && left == '0 && !wr;
   endfunction : step_allowed

   assign mode = (i_clock_source_select == SRC_EXTERNAL) ?
                 MODE_COUNTER : MODE_TIMER;

   // two-stage synchroniser; only pin_sync feeds the edge detector
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         pin_last <= 1'b0;
      end else begin
         pin_meta <= i_external_count_input;
         pin_sync <= pin_meta;
         pin_last <= pin_sync;
      end
   end

   assign pin_rise = pin_sync && !pin_last;
   assign pin_fall = !pin_sync && pin_last;

   always_comb begin
      case (mode)
         MODE_TIMER:   raw_event = 1'b1;
         MODE_COUNTER: raw_event = (i_source_edge_select == EDGE_FALLING) ?
                                   pin_fall : pin_rise;
         default:      raw_event = 1'b0;
      endcase
   end

   // prescaler exclusive to this timer
   tmr8_prescaler #(.WIDTH(PRESCALE_W)) u_prescaler (
      .i_clk_sys              (i_clk_sys),
      .i_rst_n                (i_rst_n),
      .i_prescaler_bypass     (i_prescaler_bypass),
      .i_prescale_rate_select (i_prescale_rate_select),
      .i_event                (raw_event),
      .tick_port              (tick_bus.source)
   );

   assign tick_bus.clear = i_count_write;

   // hold-off counter loaded on write, blocks ticks while nonzero
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hold <= '0;
      end else if (i_count_write) begin
         hold <= WRITE_HOLD;
      end else if (hold != '0) begin
         hold <= hold - HOLD_W'(1);
      end
   end

   assign rollover = step_allowed(tick_bus.tick, hold, i_count_write) &&
                     o_count_register == COUNT_MAX;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_count_register <= COUNT_RESET;
      end else if (i_count_write) begin
         o_count_register <= i_count_wdata;
      end else if (step_allowed(tick_bus.tick, hold, i_count_write)) begin
         o_count_register <= o_count_register + W'(1);
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_overflow_flag <= 1'b0;
      end else if (rollover) begin
         o_overflow_flag <= 1'b1;
      end else if (i_overflow_flag_clear) begin
         o_overflow_flag <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_overflow_gate <= 1'b0;
      end else begin
         o_overflow_gate <= rollover;
      end
   end

   assign o_overflow_irq = o_overflow_flag && i_overflow_irq_enable;

   default clocking chk_cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);

   // write cycle followed by the first cycle of hold-off
   sequence write_seq;
      i_count_write ##1 !i_count_write;
   endsequence

   // overflow taken while the interrupt stays enabled across the set
   sequence wrap_enabled_seq;
      (rollover && i_overflow_irq_enable) ##1 i_overflow_irq_enable;
   endsequence

   // a qualifying pin edge that nothing holds back, prescaler bypassed
   sequence pin_step_seq;
      i_clock_source_select && i_prescaler_bypass && raw_event &&
      step_allowed(tick_bus.tick, hold, i_count_write);
   endsequence

   // the loaded value stands over both hold-off edges; only a fresh
   // write may replace it at the second one
   write_hold_a : assert property (
      write_seq |=> $stable(o_count_register) ##1
      ($past(i_count_write) || $stable(o_count_register)))
      else $error("count moved during write hold-off");
   hold_load_a : assert property (
      i_count_write |=> hold == WRITE_HOLD)
      else $error("hold-off not armed by write");
   timer_step_a : assert property (
      (!i_clock_source_select && i_prescaler_bypass && hold == '0 &&
       !i_count_write) |=>
      o_count_register == W'($past(o_count_register) + 1))
      else $error("timer mode did not step by one");
   count_load_a : assert property (
      i_count_write |=> o_count_register == $past(i_count_wdata))
      else $error("count write not loaded");

   flag_set_a : assert property (
      rollover |=> o_overflow_flag && o_count_register == COUNT_RESET &&
      o_overflow_gate)
      else $error("rollover did not set flag");
   flag_sticky_a : assert property (
      (o_overflow_flag && !i_overflow_flag_clear) |=> o_overflow_flag)
      else $error("flag dropped without clear");
   clear_race_a : assert property (
      (rollover && i_overflow_flag_clear) |=> o_overflow_flag)
      else $error("clear beat a rollover in the same cycle");
   flag_clear_a : assert property (
      (i_overflow_flag_clear && !rollover) |=> !o_overflow_flag)
      else $error("flag clear ignored");
   irq_gate_a : assert property (
      o_overflow_irq == (o_overflow_flag && i_overflow_irq_enable))
      else $error("irq not flag gated by enable");
   irq_follow_a : assert property (
      wrap_enabled_seq |-> o_overflow_irq)
      else $error("enabled rollover raised no interrupt");
   gate_pulse_a : assert property (
      o_overflow_gate |=> !o_overflow_gate)
      else $error("gate pulse longer than one cycle");

   sync_stage_a : assert property (
      pin_sync == $past(pin_meta))
      else $error("pin synchroniser skipped a stage");
   edge_flop_a : assert property (
      pin_last == $past(pin_sync))
      else $error("edge detector not fed by second stage");
   pin_count_a : assert property (
      (i_clock_source_select && !pin_rise && !pin_fall) |-> !raw_event)
      else $error("counter mode moved without pin edge");
   pin_step_a : assert property (
      pin_step_seq |=> o_count_register == W'($past(o_count_register) + 1))
      else $error("pin edge did not step the count");
   edge_sel_a : assert property (
      (i_clock_source_select && i_source_edge_select && pin_rise) |->
      !raw_event)
      else $error("rising edge counted in falling mode");
   rise_only_a : assert property (
      (i_clock_source_select && !i_source_edge_select && pin_fall) |->
      !raw_event)
      else $error("falling edge counted in rising mode");
   timer_mode_a : assert property (
      !i_clock_source_select |-> raw_event)
      else $error("timer mode lost instruction tick");
endmodule : tmr8_timer
